/* File: core/phy_regs_pkg.sv */
/*
   Shared constants and carriers for the transceiver management register bank.
   Assumes a 16-bit register word and a 5-bit register index from the serial management front end.
*/
package phy_regs_pkg;

   localparam int RegWidth = 16;
   localparam int IndexWidth = 5;

   // Register indices
   localparam logic [4:0] IdxBasicControl = 5'h00;
   localparam logic [4:0] IdxBasicStatus = 5'h01;
   localparam logic [4:0] IdxPhyIdUpper = 5'h02;
   localparam logic [4:0] IdxPhyIdLower = 5'h03;
   localparam logic [4:0] IdxAnegAdvertise = 5'h04;
   localparam logic [4:0] IdxAnegPartnerAbility = 5'h05;
   localparam logic [4:0] IdxAnegExpansion = 5'h06;
   localparam logic [4:0] IdxAnegNextPage = 5'h07;
   localparam logic [4:0] IdxPartnerNextPage = 5'h08;
   localparam logic [4:0] IdxAfeControl = 5'h11;
   localparam logic [4:0] IdxRxErrCounter = 5'h15;
   localparam logic [4:0] IdxStrapOverride = 5'h16;
   localparam logic [4:0] IdxStrapStatus = 5'h17;
   localparam logic [4:0] IdxExpandedControl = 5'h18;
   localparam logic [4:0] IdxIntCtrlStatus = 5'h1b;
   localparam logic [4:0] IdxCableDiag = 5'h1d;
   localparam logic [4:0] IdxPhyControlOne = 5'h1e;
   localparam logic [4:0] IdxPhyControlTwo = 5'h1f;

   // Basic control field positions
   localparam int BitReset = 15;
   localparam int BitLoopback = 14;
   localparam int BitSpeed = 13;
   localparam int BitAnegEnable = 12;
   localparam int BitPowerDown = 11;
   localparam int BitIsolate = 10;
   localparam int BitAnegRestart = 9;
   localparam int BitDuplex = 8;
   localparam int BitCollisionTest = 7;

   // Zero word and the fixed read value of basic status
   localparam logic [15:0] ResetZero = 16'h0000;
   localparam logic [15:0] BasicStatusValue = 16'h7840;

   // Strap levels captured at reset
   typedef struct packed {
      logic speed;
      logic autoneg;
      logic isolate;
      logic duplex;
   } strap_t;

   // One register access from the management front end
   typedef struct packed {
      logic wrEn;
      logic [4:0] index;
      logic [15:0] wrData;
   } reg_req_t;

   // Mode decoded from basic control for the transceiver core
   typedef struct packed {
      logic coreReset;
      logic loopback;
      logic speed100;
      logic fullDuplex;
      logic anegEnable;
      logic anegRestart;
      logic powerDown;
      logic isolate;
      logic collisionTest;
   } phy_mode_t;

endpackage

/* File: core/phy_basic_control_regs.sv */
/*
   Management register bank of a 10/100 transceiver: basic control with strap-derived reset values,
   storage for the writable mapped registers, and the decoded operating mode for the transceiver core.
   Assumes the serial management front end delivers one synchronous request per cycle on mclk, that
   strap pins are static board levels, and that auto-negotiation results arrive from the core.
*/
`timescale 1ns/1ps
module phy_basic_control_regs
   import phy_regs_pkg::*;
#(
   parameter logic [15:0] PhyIdUpper = 16'h1234, // Arbitrary identity value
   parameter logic [15:0] PhyIdLower = 16'h5670  // Arbitrary identity value
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire phy_regs_pkg::reg_req_t req,
   output logic [15:0] rdData,
   input wire logic speedStrapPin,
   input wire logic autoneg_strap_pin,
   input wire logic isoStrapPin,
   input wire logic duplexStrapPin,
   input wire logic anegSpeed100,
   input wire logic anegFullDuplex,
   input wire logic [15:0] intStatusIn,
   input wire logic [15:0] rxErrCount,
   input wire logic [15:0] cableDiagStatus,
   output phy_regs_pkg::phy_mode_t mode
);
   import phy_regs_pkg::*;

   // Whole register state in one struct
   typedef struct packed {
      logic [3:0] strapMeta;
      logic [3:0] strapSync;
      logic strapPending;
      strap_t straps;
      logic resetPulse;
      logic restartPulse;
      logic loopback;
      logic speed;
      logic anegEnable;
      logic powerDown;
      logic isolate;
      logic duplex;
      logic collisionTest;
      logic [15:0] advertise;
      logic [15:0] nextPage;
      logic [15:0] afeControl;
      logic [15:0] strapOverride;
      logic [15:0] expandedControl;
      logic [15:0] intEnable;
      logic [15:0] cableControl;
      logic [15:0] controlOne;
      logic [15:0] controlTwo;
      logic [15:0] rdData;
   } state_t;

   state_t s_q;
   state_t s_d;
   logic [3:0] strapPins;
   logic wrCtrl;
   logic [15:0] rdNext;

   assign strapPins = {speedStrapPin, autoneg_strap_pin, isoStrapPin, duplexStrapPin};
   assign wrCtrl = req.wrEn && (req.index == IdxBasicControl);

   // Read mux; unmapped and reserved indices return zero
   always_comb begin
      rdNext = ResetZero;
      if (req.index == IdxBasicControl) begin
         rdNext = ResetZero;
         rdNext[BitLoopback] = s_q.loopback;
         rdNext[BitSpeed] = s_q.speed;
         rdNext[BitAnegEnable] = s_q.anegEnable;
         rdNext[BitPowerDown] = s_q.powerDown;
         rdNext[BitIsolate] = s_q.isolate;
         rdNext[BitDuplex] = s_q.duplex;
         rdNext[BitCollisionTest] = s_q.collisionTest;
      end else if (req.index == IdxBasicStatus) begin
         rdNext = BasicStatusValue;
      end else if (req.index == IdxPhyIdUpper) begin
         rdNext = PhyIdUpper;
      end else if (req.index == IdxPhyIdLower) begin
         rdNext = PhyIdLower;
      end else if (req.index == IdxAnegAdvertise) begin
         rdNext = s_q.advertise;
      end else if (req.index == IdxAnegNextPage) begin
         rdNext = s_q.nextPage;
      end else if (req.index == IdxAfeControl) begin
         rdNext = s_q.afeControl;
      end else if (req.index == IdxRxErrCounter) begin
         rdNext = rxErrCount;
      end else if (req.index == IdxStrapOverride) begin
         rdNext = s_q.strapOverride;
      end else if (req.index == IdxStrapStatus) begin
         rdNext = {12'h000, s_q.straps};
      end else if (req.index == IdxExpandedControl) begin
         rdNext = s_q.expandedControl;
      end else if (req.index == IdxIntCtrlStatus) begin
         rdNext = {s_q.intEnable[15:8], intStatusIn[7:0]};
      end else if (req.index == IdxCableDiag) begin
         rdNext = {s_q.cableControl[15:8], cableDiagStatus[7:0]};
      end else if (req.index == IdxPhyControlOne) begin
         rdNext = s_q.controlOne;
      end else if (req.index == IdxPhyControlTwo) begin
         rdNext = s_q.controlTwo;
      end
   end

   // Next-state logic for straps, control bits and storage
   always_comb begin
      s_d = s_q;
      // Two-stage synchroniser on the strap pins
      s_d.strapMeta = strapPins;
      s_d.strapSync = s_q.strapMeta;
      s_d.resetPulse = 1'b0;
      s_d.restartPulse = 1'b0;
      s_d.rdData = rdNext;
      // Straps are latched one cycle after the synchroniser has settled after any reset
      if (s_q.strapPending) begin
         s_d.strapPending = 1'b0;
         s_d.straps = '{speed: s_q.strapSync[3], autoneg: s_q.strapSync[2],
                        isolate: s_q.strapSync[1], duplex: s_q.strapSync[0]};
         s_d.speed = s_q.strapSync[3];
         s_d.anegEnable = s_q.strapSync[2];
         s_d.isolate = s_q.strapSync[1];
         s_d.duplex = ~s_q.strapSync[0];
      end else if (wrCtrl) begin
         if (req.wrData[BitReset] && s_q.powerDown) begin
            // First reset write only leaves power down
            s_d.powerDown = 1'b0;
         end else if (req.wrData[BitReset]) begin
            // Soft reset: all bits to defaults, straps re-latched next cycle
            s_d = state_t'(0);
            s_d.strapMeta = strapPins;
            s_d.strapSync = s_q.strapMeta;
            s_d.rdData = rdNext;
            s_d.resetPulse = 1'b1;
            s_d.strapPending = 1'b1;
         end else begin
            s_d.loopback = req.wrData[BitLoopback];
            s_d.speed = req.wrData[BitSpeed];
            s_d.anegEnable = req.wrData[BitAnegEnable];
            s_d.powerDown = req.wrData[BitPowerDown];
            s_d.isolate = req.wrData[BitIsolate];
            s_d.duplex = req.wrData[BitDuplex];
            s_d.collisionTest = req.wrData[BitCollisionTest];
            s_d.restartPulse = req.wrData[BitAnegRestart];
         end
      end else if (req.wrEn) begin
         // Plain storage registers; read-only and reserved indices ignore writes
         if (req.index == IdxAnegAdvertise) begin
            s_d.advertise = req.wrData;
         end else if (req.index == IdxAnegNextPage) begin
            s_d.nextPage = req.wrData;
         end else if (req.index == IdxAfeControl) begin
            s_d.afeControl = req.wrData;
         end else if (req.index == IdxStrapOverride) begin
            s_d.strapOverride = req.wrData;
         end else if (req.index == IdxExpandedControl) begin
            s_d.expandedControl = req.wrData;
         end else if (req.index == IdxIntCtrlStatus) begin
            s_d.intEnable = {req.wrData[15:8], 8'h00};
         end else if (req.index == IdxCableDiag) begin
            s_d.cableControl = {req.wrData[15:8], 8'h00};
         end else if (req.index == IdxPhyControlOne) begin
            s_d.controlOne = req.wrData;
         end else if (req.index == IdxPhyControlTwo) begin
            s_d.controlTwo = req.wrData;
         end
      end
   end

   // Power-on reset forces constants; strap capture follows release
   always_ff @(posedge mclk) begin
      if (!resetn) begin
         s_q <= state_t'(0);
         s_q.strapPending <= 1'b1;
         // Synchroniser keeps running through reset so the first latch sees settled strap levels
         s_q.strapMeta <= strapPins;
         s_q.strapSync <= s_q.strapMeta;
      end else begin
         s_q <= s_d;
      end
   end

   assign rdData = s_q.rdData;

   // Decoded mode; power down gates loopback, negotiation and collision test and forces isolation, but leaves registers alone
   always_comb begin
      mode.coreReset = s_q.resetPulse || s_q.strapPending;
      mode.powerDown = s_q.powerDown;
      mode.loopback = s_q.loopback && !s_q.powerDown;
      mode.anegEnable = s_q.anegEnable && !s_q.powerDown;
      mode.anegRestart = s_q.restartPulse && !s_q.powerDown;
      mode.speed100 = s_q.anegEnable ? anegSpeed100 : s_q.speed;
      mode.fullDuplex = s_q.anegEnable ? anegFullDuplex : s_q.duplex;
      mode.isolate = s_q.isolate || s_q.powerDown;
      mode.collisionTest = s_q.collisionTest && !s_q.powerDown;
   end

   // Reset bit self-clears: a write of one never reads back as one
   property p_reset_reads_zero;
      @(posedge mclk) disable iff (!resetn)
      (req.index == IdxBasicControl) |=> !rdData[BitReset];
   endproperty
   a_reset_reads_zero: assert property (p_reset_reads_zero) else $error("reset bit read back as one");

   property p_reset_relatch;
      @(posedge mclk) disable iff (!resetn)
      (wrCtrl && req.wrData[BitReset] && !s_q.powerDown && !s_q.strapPending) |=> ##1 (s_q.speed == s_q.straps.speed);
   endproperty
   a_reset_relatch: assert property (p_reset_relatch) else $error("speed not taken from strap after reset");

   property p_pd_first_write;
      @(posedge mclk) disable iff (!resetn)
      (wrCtrl && req.wrData[BitReset] && s_q.powerDown && !s_q.strapPending) |=> (!s_q.powerDown && !s_q.resetPulse);
   endproperty
   a_pd_first_write: assert property (p_pd_first_write) else $error("first reset write in power down misbehaved");

   property p_pd_write;
      @(posedge mclk) disable iff (!resetn)
      (wrCtrl && !req.wrData[BitReset] && !s_q.strapPending) |=> (mode.powerDown == $past(req.wrData[BitPowerDown]));
   endproperty
   a_pd_write: assert property (p_pd_write) else $error("power down bit not written");

   property p_pd_gates;
      @(posedge mclk) disable iff (!resetn)
      s_q.powerDown |-> (!mode.loopback && !mode.anegRestart && mode.isolate);
   endproperty
   a_pd_gates: assert property (p_pd_gates) else $error("core function active in power down");

   property p_restart_pulse;
      @(posedge mclk) disable iff (!resetn)
      (wrCtrl && req.wrData[BitAnegRestart] && !req.wrData[BitReset] && !s_q.powerDown
       && !s_q.strapPending) |=> s_q.restartPulse ##1 !s_q.restartPulse;
   endproperty
   a_restart_pulse: assert property (p_restart_pulse) else $error("restart not a single pulse");

   property p_speed_select;
      @(posedge mclk) disable iff (!resetn)
      !s_q.anegEnable |-> (mode.speed100 == s_q.speed && mode.fullDuplex == s_q.duplex);
   endproperty
   a_speed_select: assert property (p_speed_select) else $error("manual speed or duplex not applied");

   property p_aneg_override;
      @(posedge mclk) disable iff (!resetn)
      s_q.anegEnable |-> (mode.speed100 == anegSpeed100 && mode.fullDuplex == anegFullDuplex);
   endproperty
   a_aneg_override: assert property (p_aneg_override) else $error("negotiated result not applied");

   property p_strap_defaults;
      @(posedge mclk) disable iff (!resetn)
      (resetn && s_q.strapPending) |=> (s_q.anegEnable == s_q.straps.autoneg
                            && s_q.isolate == s_q.straps.isolate && s_q.duplex == !s_q.straps.duplex);
   endproperty
   a_strap_defaults: assert property (p_strap_defaults) else $error("strap default not applied");

   property p_reserved_zero;
      @(posedge mclk) disable iff (!resetn)
      (req.index == 5'h1c || req.index == 5'h09) |=> (rdData == 16'h0000);
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved register not zero");

   // Soft reset raises the core reset for one cycle and then drops it by itself
   property p_reset_self_clear;
      @(posedge mclk) disable iff (!resetn)
      (wrCtrl && req.wrData[BitReset] && !s_q.powerDown && !s_q.strapPending)
      |=> (s_q.resetPulse && mode.coreReset) ##1 !s_q.resetPulse;
   endproperty
   a_reset_self_clear: assert property (p_reset_self_clear) else $error("soft reset pulse did not clear");

   // Speed default follows the synchronised strap level, after power-on and soft reset alike
   property p_speed_strap;
      @(posedge mclk) disable iff (!resetn)
      (resetn && s_q.strapPending) |=> (s_q.speed == $past(s_q.strapSync[3]));
   endproperty
   a_speed_strap: assert property (p_speed_strap) else $error("speed default not taken from strap");

   // A plain control write lands in the loopback bit in the next cycle
   property p_loopback_write;
      @(posedge mclk) disable iff (!resetn)
      (wrCtrl && !req.wrData[BitReset] && !s_q.strapPending) |=> (s_q.loopback == $past(req.wrData[BitLoopback]));
   endproperty
   a_loopback_write: assert property (p_loopback_write) else $error("loopback bit not written");

   // Isolation is software controlled once the straps have been taken
   property p_isolate_write;
      @(posedge mclk) disable iff (!resetn)
      (wrCtrl && !req.wrData[BitReset] && !s_q.strapPending) |=> (s_q.isolate == $past(req.wrData[BitIsolate]));
   endproperty
   a_isolate_write: assert property (p_isolate_write) else $error("isolate bit not written");

   // Duplex is written straight, only its reset value is inverted
   property p_duplex_write;
      @(posedge mclk) disable iff (!resetn)
      (wrCtrl && !req.wrData[BitReset] && !s_q.strapPending) |=> (s_q.duplex == $past(req.wrData[BitDuplex]));
   endproperty
   a_duplex_write: assert property (p_duplex_write) else $error("duplex bit not written");

   // Strap status is read-only: a write there never disturbs the latched levels
   property p_strap_status_ro;
      @(posedge mclk) disable iff (!resetn)
      (req.wrEn && req.index == IdxStrapStatus && !s_q.strapPending) |=> $stable(s_q.straps);
   endproperty
   a_strap_status_ro: assert property (p_strap_status_ro) else $error("strap status changed by a write");

   // Only the enable byte of the interrupt register is stored; status bits come from the core
   property p_int_low_byte;
      @(posedge mclk) disable iff (!resetn)
      (req.wrEn && req.index == IdxIntCtrlStatus && !s_q.strapPending)
      |=> (s_q.intEnable == {$past(req.wrData[15:8]), 8'h00});
   endproperty
   a_int_low_byte: assert property (p_int_low_byte) else $error("interrupt enable byte not stored");

   // Management writes still land while the core is powered down
   property p_pd_storage;
      @(posedge mclk) disable iff (!resetn)
      (s_q.powerDown && req.wrEn && req.index == IdxAnegAdvertise && !s_q.strapPending)
      |=> (s_q.advertise == $past(req.wrData));
   endproperty
   a_pd_storage: assert property (p_pd_storage) else $error("write lost in power down");

   // Low seven bits of basic control are reserved and always read zero
   property p_ctrl_reserved_bits;
      @(posedge mclk) disable iff (!resetn)
      (req.index == IdxBasicControl) |=> (rdData[6:0] == 7'h00);
   endproperty
   a_ctrl_reserved_bits: assert property (p_ctrl_reserved_bits) else $error("reserved control bits not zero");

endmodule

/* File: bench/mgmt_station.sv */
/*
   Model of the station management controller that faces the register bank.
   Assumes requests are taken on each rising mclk edge and read data is registered one cycle later.
*/
`timescale 1ns/1ps
module mgmt_station (
   input wire logic mclk,
   input wire logic [15:0] rdData,
   output phy_regs_pkg::reg_req_t req
);
   import phy_regs_pkg::*;

   // Idle request is a harmless read of index 0
   initial begin
      req = '0;
   end

   // One write, held until the edge that takes it; a reset write out of power down is one call,
   // so the caller sequences the wake write and the real reset write as two calls
   task automatic write_reg(input logic [4:0] idx, input logic [15:0] data);
      @(posedge mclk);
      req <= '{wrEn: 1'b1, index: idx, wrData: data};
      @(posedge mclk);
      req <= '0;
   endtask

   // Index driven after one edge and taken by the next, so the word sampled at the falling edge belongs to it alone
   task automatic read_reg(input logic [4:0] idx, output logic [15:0] data);
      @(posedge mclk);
      req <= '{wrEn: 1'b0, index: idx, wrData: 16'h0000};
      @(posedge mclk);
      @(negedge mclk);
      data = rdData;
   endtask
endmodule

/* File: bench/tb_top.sv */
/*
   Self-checking bench for the management register bank.
   Assumes the station model above drives requests and strap pins stay static except where changed.
*/
`timescale 1ns/1ps
module tb_top;
   import phy_regs_pkg::*;
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic speedStrapPin = 1'b1;
   logic autoneg_strap_pin = 1'b0;
   logic isoStrapPin = 1'b1;
   logic duplexStrapPin = 1'b0;
   logic anegSpeed100 = 1'b0;
   logic anegFullDuplex = 1'b0;
   logic [15:0] intStatusIn = 16'h005a;
   logic [15:0] rxErrCount = 16'hbeef;
   logic [15:0] cableDiagStatus = 16'h0033;
   logic [15:0] rdData;
   logic [15:0] word;
   reg_req_t req;
   phy_mode_t mode;
   int fails = 0;
   int comparisons = 0;
   logic [4:0] roIdx [6] = '{5'h01, 5'h02, 5'h03, 5'h15, 5'h17, 5'h1d};
   logic [15:0] roVal [6] = '{16'h7840, 16'h0abc, 16'h0def, 16'hbeef, 16'h000a, 16'hff33};
   logic [4:0] rwIdx [6] = '{5'h04, 5'h07, 5'h11, 5'h18, 5'h1e, 5'h1f};

   // Free-running 100 MHz clock
   always #5 mclk = ~mclk;

   mgmt_station station (.mclk(mclk), .rdData(rdData), .req(req));

   phy_basic_control_regs #(.PhyIdUpper(16'h0abc), .PhyIdLower(16'h0def)) uut (
      .mclk(mclk), .resetn(resetn), .req(req), .rdData(rdData),
      .speedStrapPin(speedStrapPin), .autoneg_strap_pin(autoneg_strap_pin), .isoStrapPin(isoStrapPin),
      .duplexStrapPin(duplexStrapPin), .anegSpeed100(anegSpeed100), .anegFullDuplex(anegFullDuplex),
      .intStatusIn(intStatusIn), .rxErrCount(rxErrCount), .cableDiagStatus(cableDiagStatus), .mode(mode)
   );

   // Word and bit comparisons count every check and report mismatches at once
   task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic expect_reg(input logic [4:0] idx, input logic [15:0] exp);
      station.read_reg(idx, word);
      check_word(word, exp);
   endtask

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Hang guard: the whole run needs far fewer cycles than this
   initial begin
      repeat (5000) @(posedge mclk);
      fails++;
      end_of_test();
   end

   // Main sequence
   initial begin
      repeat (20) @(posedge mclk);
      resetn <= 1'b1;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      check_bit(mode.coreReset, 1'b0);
      check_bit(mode.isolate, 1'b1);
      check_bit(mode.speed100, 1'b1);
      expect_reg(IdxBasicControl, 16'h2500);
      for (int i = 0; i < 6; i++) begin
         station.write_reg(roIdx[i], 16'hffff);
         expect_reg(roIdx[i], roVal[i]);
      end
      expect_reg(IdxIntCtrlStatus, 16'h005a);
      station.write_reg(IdxIntCtrlStatus, 16'hffff);
      expect_reg(IdxIntCtrlStatus, 16'hff5a);
      station.write_reg(IdxStrapOverride, 16'h1234);
      expect_reg(IdxStrapOverride, 16'h1234);
      // Plain storage registers keep a full 16-bit word
      for (int i = 0; i < 6; i++) begin
         station.write_reg(rwIdx[i], {11'h5a3, rwIdx[i]});
         expect_reg(rwIdx[i], {11'h5a3, rwIdx[i]});
      end
      // Reserved indices swallow writes and read zero
      for (int i = 0; i < 32; i++) begin
         if ((i >= 9 && i <= 16) || (i >= 18 && i <= 20) || i == 25 || i == 26 || i == 28) begin
            station.write_reg(i[4:0], 16'hffff);
            expect_reg(i[4:0], 16'h0000);
         end
      end
      // Negotiated result must win over the manual speed and duplex bits
      station.write_reg(IdxBasicControl, 16'h3300);
      @(negedge mclk);
      check_bit(mode.anegRestart, 1'b1);
      @(negedge mclk);
      check_bit(mode.anegRestart, 1'b0);
      check_bit(mode.speed100, 1'b0);
      check_bit(mode.fullDuplex, 1'b0);
      check_bit(mode.anegEnable, 1'b1);
      expect_reg(IdxBasicControl, 16'h3100);
      station.write_reg(IdxBasicControl, 16'h2100);
      @(negedge mclk);
      check_bit(mode.anegRestart, 1'b0);
      check_bit(mode.speed100, 1'b1);
      check_bit(mode.fullDuplex, 1'b1);
      station.write_reg(IdxBasicControl, 16'h40ff);
      @(negedge mclk);
      check_bit(mode.loopback, 1'b1);
      check_bit(mode.collisionTest, 1'b1);
      check_bit(mode.isolate, 1'b0);
      expect_reg(IdxBasicControl, 16'h4080);
      station.write_reg(IdxBasicControl, 16'h0800);
      @(negedge mclk);
      check_bit(mode.loopback, 1'b0);
      check_bit(mode.powerDown, 1'b1);
      station.write_reg(IdxBasicControl, 16'h0000);
      @(negedge mclk);
      check_bit(mode.powerDown, 1'b0);
      // Power down keeps the management side usable; leaving it by reset needs two writes
      station.write_reg(IdxBasicControl, 16'h0800);
      station.write_reg(IdxAnegAdvertise, 16'h01e1);
      expect_reg(IdxAnegAdvertise, 16'h01e1);
      expect_reg(IdxBasicControl, 16'h0800);
      @(posedge mclk);
      speedStrapPin <= 1'b0;
      station.write_reg(IdxBasicControl, 16'h8000);
      @(negedge mclk);
      check_bit(mode.powerDown, 1'b0);
      check_bit(mode.coreReset, 1'b0);
      expect_reg(IdxBasicControl, 16'h0000);
      station.write_reg(IdxBasicControl, 16'h8000);
      @(negedge mclk);
      check_bit(mode.coreReset, 1'b1);
      repeat (3) @(posedge mclk);
      expect_reg(IdxBasicControl, 16'h0500);
      expect_reg(IdxStrapStatus, 16'h0002);
      end_of_test();
   end
endmodule
